// ===== pkg/rss_pkg.sv
package rss_pkg;

	localparam int ROM_COUNT = 12;
	localparam int SECTOR_BITS = 6;
	localparam int OFFSET_BITS = 10;
	localparam int ROM_DEPTH = 1024;
	localparam int ADDR_BITS = 16;
	localparam logic [15:0] UTIL_LO = 16'h8000;
	localparam logic [15:0] UTIL_HI = 16'h81FF;
	localparam logic [15:0] RUN_START = 16'h8000;
	localparam logic [15:0] RESET_START = 16'h0000;
	localparam logic [1:0] CEI_ACT_HIGH = 2'h0;
	localparam logic [1:0] CEI_ACT_LOW = 2'h1;
	localparam logic [1:0] CEI_ABSENT = 2'h2;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] HIGH_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] data;
		logic drive;
	} rss_bus_s;

	typedef logic [SECTOR_BITS-1:0] rss_sector_t;

endpackage

// ===== design/rss_rom_mem.sv
`timescale 1ns/100ps
module rss_rom_mem (
	// clocking
	input wire logic clk,
	input wire logic ce,
	// read port
	input wire logic [9:0] addr,
	output logic [7:0] rdata
);
	import rss_pkg::*;

	logic [7:0] mem [ROM_DEPTH];
	logic [7:0] rdata_ff;

	// fixed pattern standing in for the mask content
	always_comb begin
		for (int i = 0; i < ROM_DEPTH; i++) begin
			mem[i] = 8'(i);
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			rdata_ff <= mem[addr];
		end
	end

	assign rdata = rdata_ff;
endmodule

// ===== design/rss_select_chain.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module rss_select_chain #(
	parameter logic [1:0] CEI_MODE = rss_pkg::CEI_ACT_HIGH,
	parameter logic [rss_pkg::ROM_COUNT-1:0] FITTED = 12'h001,
	parameter logic [rss_pkg::ROM_COUNT*rss_pkg::SECTOR_BITS-1:0] SECTORS = 72'h0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// processor bus
	input wire logic [7:0] multiplexed_address_lines,
	input wire logic address_latch_pulse,
	input wire logic memory_read_strobe_n,
	input wire logic run_utility,
	// external chain input
	input wire logic chain_enable_in,
	// results
	output rss_pkg::rss_bus_s data_bus,
	output logic chain_enable_out,
	output logic ram_decoder_disable,
	output logic utility_rom_select,
	output logic [15:0] fetch_start
);
	import rss_pkg::*;

	typedef enum logic [1:0] {
		RUN_IDLE = 2'b01,
		RUN_UTIL = 2'b10
	} rss_run_e;

	// address latch
	logic [7:0] high_ff;
	logic [7:0] nxt_high;
	logic tpa_ff;
	logic nxt_tpa;
	logic pulse_fall;
	logic [ADDR_BITS-1:0] addr;
	// sector decode and chain
	logic cei_level;
	logic [ROM_COUNT-1:0] sel;
	logic [ROM_COUNT:0] chain;
	logic [7:0] rd [ROM_COUNT];
	logic [7:0] gated [ROM_COUNT];
	logic [7:0] merge [ROM_COUNT+1];
	logic any_sel;
	logic claim;
	// data bus
	rss_bus_s bus_ff;
	rss_bus_s nxt_bus;
	// select outputs
	logic ceo_ff;
	logic nxt_ceo;
	logic ram_ff;
	logic nxt_ram;
	logic util_ff;
	logic nxt_util;
	logic upper_half;
	logic above_lo;
	logic below_hi;
	logic in_window;
	// run command
	rss_run_e run_ff;
	rss_run_e nxt_run;
	logic [15:0] start_ff;
	logic [15:0] nxt_start;

	////////////////////////////////////////////////////////////////////////////
	// address latch
	always_comb begin
		nxt_tpa = address_latch_pulse;
		nxt_high = high_ff;
		pulse_fall = tpa_ff && !address_latch_pulse;
		if (pulse_fall) begin
			nxt_high = multiplexed_address_lines;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_ff <= HIGH_RESET;
			tpa_ff <= 1'b0;
		end else if (ce) begin
			high_ff <= nxt_high;
			tpa_ff <= nxt_tpa;
		end
	end

	assign addr = {high_ff, multiplexed_address_lines};

	////////////////////////////////////////////////////////////////////////////
	// chain input conditioning
	always_comb begin
		unique case (CEI_MODE)
			CEI_ACT_HIGH: cei_level = chain_enable_in;
			CEI_ACT_LOW: cei_level = !chain_enable_in;
			CEI_ABSENT: cei_level = 1'b0;
			default: cei_level = 1'b0;
		endcase
	end

	assign chain[0] = cei_level;
	assign merge[0] = DATA_RESET;

	////////////////////////////////////////////////////////////////////////////
	// sector roms
	genvar g;
	generate
		for (g = 0; g < ROM_COUNT; g++) begin : g_rom
			assign sel[g] = FITTED[g] &&
				(addr[ADDR_BITS-1 -: SECTOR_BITS] ==
				SECTORS[g*SECTOR_BITS +: SECTOR_BITS]);
			assign chain[g+1] = chain[g] | sel[g];
			assign gated[g] = sel[g] ? rd[g] : DATA_RESET;
			assign merge[g+1] = merge[g] | gated[g];
			rss_rom_mem u_mem (
				.clk(clk),
				.ce(ce),
				.addr(addr[OFFSET_BITS-1:0]),
				.rdata(rd[g])
			);
		end
	endgenerate

	assign any_sel = |sel;
	assign claim = chain[ROM_COUNT];

	////////////////////////////////////////////////////////////////////////////
	// data bus
	always_comb begin
		nxt_bus.drive = any_sel && !memory_read_strobe_n;
		nxt_bus.data = DATA_RESET;
		if (nxt_bus.drive) begin
			nxt_bus.data = merge[ROM_COUNT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ff <= '0;
		end else if (ce) begin
			bus_ff <= nxt_bus;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chain, ram and utility selects
	always_comb begin
		upper_half = addr[ADDR_BITS-1];
		above_lo = addr >= UTIL_LO;
		below_hi = addr <= UTIL_HI;
		in_window = above_lo && below_hi;
		nxt_ceo = claim;
		nxt_ram = claim | upper_half;
		nxt_util = in_window && !claim;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ceo_ff <= 1'b0;
			ram_ff <= 1'b0;
			util_ff <= 1'b0;
		end else if (ce) begin
			ceo_ff <= nxt_ceo;
			ram_ff <= nxt_ram;
			util_ff <= nxt_util;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// run command
	always_comb begin
		nxt_run = run_ff;
		unique case (run_ff)
			RUN_IDLE: begin
				if (run_utility) begin
					nxt_run = RUN_UTIL;
				end
			end
			RUN_UTIL: begin
				nxt_run = RUN_UTIL;
			end
			default: begin
				nxt_run = RUN_IDLE;
			end
		endcase
		nxt_start = RESET_START;
		if (nxt_run == RUN_UTIL) begin
			nxt_start = RUN_START;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= RUN_IDLE;
			start_ff <= RESET_START;
		end else if (ce) begin
			run_ff <= nxt_run;
			start_ff <= nxt_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign data_bus = bus_ff;
	assign chain_enable_out = ceo_ff;
	assign ram_decoder_disable = ram_ff;
	assign utility_rom_select = util_ff;
	assign fetch_start = start_ff;
endmodule

// ===== verification/rss_select_chain_chk.sv
`timescale 1ns/100ps
module rss_select_chain_chk (
	// watched ports
	input wire logic clk, rst_n, ce, address_latch_pulse, memory_read_strobe_n,
	input wire logic run_utility, chain_enable_in, chain_enable_out,
	input wire logic ram_decoder_disable, utility_rom_select,
	input wire logic [7:0] multiplexed_address_lines,
	input wire rss_pkg::rss_bus_s data_bus,
	input wire logic [15:0] fetch_start
);
import rss_pkg::*;
logic pl_ff;
logic [7:0] hi_ff;
always_ff @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		pl_ff <= 1'b0;
		hi_ff <= 8'h00;
	end else if (ce) begin
		pl_ff <= address_latch_pulse;
		if (pl_ff && !address_latch_pulse) hi_ff <= multiplexed_address_lines;
	end
end
wire [15:0] adr = {hi_ff, multiplexed_address_lines};
wire sel = adr[15:10] == 6'h00;
wire chn = sel | chain_enable_in;
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence held;
	ce && sel && !memory_read_strobe_n ##1 ce && !memory_read_strobe_n && $stable(adr);
endsequence
chain_or_a: assert property (rst_n && ce |=> chain_enable_out == $past(chn))
	else $error("chain out");
ram_block_a: assert property (rst_n && ce |=> ram_decoder_disable == $past(chn | adr[15]))
	else $error("ram disable");
util_win_a: assert property (rst_n && ce |=> utility_rom_select ==
	$past(adr >= UTIL_LO && adr <= UTIL_HI && !chn))
	else $error("utility select");
drive_a: assert property (rst_n && ce |=> data_bus.drive == $past(sel && !memory_read_strobe_n))
	else $error("drive");
data_hold_a: assert property (held |=> data_bus.data == $past(adr[7:0]))
	else $error("data");
fetch_go_a: assert property (ce && run_utility |=> fetch_start == RUN_START)
	else $error("fetch start");
fetch_hold_a: assert property (ce && !run_utility |=> $stable(fetch_start))
	else $error("fetch hold");
claim_a: assert property (data_bus.drive |-> chain_enable_out)
	else $error("claim");
util_excl_a: assert property (utility_rom_select |-> !chain_enable_out)
	else $error("utility blocked");
endmodule

// ===== verification/rss_cpu_bus.sv
`timescale 1ns/100ps
module rss_cpu_bus (
	// processor side
	input wire logic clk,
	output logic [7:0] lines,
	output logic pulse,
	output logic rd_n
);
initial begin
	lines = 8'h00;
	pulse = 1'b0;
	rd_n = 1'b1;
end
task automatic access(input logic [15:0] a);
	@(posedge clk);
	pulse <= 1'b1;
	lines <= a[15:8];
	@(posedge clk);
	pulse <= 1'b0;
	@(posedge clk);
	lines <= a[7:0];
	rd_n <= 1'b0;
	repeat (3) @(posedge clk);
	rd_n <= 1'b1;
	lines <= ~a[7:0];
endtask
endmodule

// ===== verification/rss_select_chain_tb.sv
`timescale 1ns/100ps
module rss_select_chain_tb;
import rss_pkg::*;
logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, run_utility = 1'b0, chain_enable_in = 1'b0;
logic chain_enable_out, ram_decoder_disable, utility_rom_select;
logic [7:0] multiplexed_address_lines;
logic address_latch_pulse, memory_read_strobe_n;
logic [15:0] fetch_start;
rss_pkg::rss_bus_s data_bus;
int fail_count = 0, n_tests = 0;
always #20 clk = ~clk;
rss_cpu_bus i_cpu (.clk(clk), .lines(multiplexed_address_lines),
	.pulse(address_latch_pulse), .rd_n(memory_read_strobe_n));
rss_select_chain i_dut (.*);
task chk(string n, logic [15:0] e, logic [15:0] g);
	n_tests++;
	if (g !== e) begin
		fail_count++;
		$display("CHECK FAILED %s exp %h got %h", n, e, g);
	end
endtask
task acc(logic [15:0] a, logic [3:0] e);
	i_cpu.access(a);
	#1;
	chk("flags", {12'h000, e}, {12'h000, chain_enable_out, ram_decoder_disable,
		utility_rom_select, data_bus.drive});
	if (e[0]) chk("data", {8'h00, a[7:0]}, {8'h00, data_bus.data});
endtask
task final_report;
	$display("checks %0d mismatches %0d", n_tests, fail_count);
	if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
task t_sector;
	acc(16'h0012, 4'hD);
	acc(16'h03FF, 4'hD);
	acc(16'h0400, 4'h0);
endtask
task t_window;
	acc(16'h8000, 4'h6);
	acc(16'h81FF, 4'h6);
	acc(16'h8200, 4'h4);
	acc(16'h7FFF, 4'h0);
endtask
task t_freeze;
	@(posedge clk) ce <= 1'b0;
	acc(16'h0012, 4'h0);
	@(posedge clk) ce <= 1'b1;
endtask
task t_chain;
	@(posedge clk) chain_enable_in <= 1'b1;
	acc(16'h8000, 4'hC);
	@(posedge clk) chain_enable_in <= 1'b0;
endtask
task t_run;
	#1 chk("fetch idle", RESET_START, fetch_start);
	@(posedge clk) run_utility <= 1'b1;
	@(posedge clk) run_utility <= 1'b0;
	#1 chk("fetch", RUN_START, fetch_start);
	@(posedge clk) rst_n <= 1'b0;
	repeat (2) @(posedge clk);
	#1 chk("fetch reset", RESET_START, fetch_start);
	@(posedge clk) rst_n <= 1'b1;
	repeat (2) @(posedge clk);
	#1 chk("fetch after", RESET_START, fetch_start);
endtask
initial begin
	repeat (10) @(posedge clk);
	rst_n <= 1'b1;
	t_sector;
	t_window;
	t_freeze;
	t_chain;
	t_run;
	final_report;
end
initial begin
	#20000;
	fail_count++;
	final_report;
end
endmodule
bind rss_select_chain rss_select_chain_chk i_chk (.*);
